// ===== design/drps_core.sv
// refresh, self-refresh and power-down state tracking of the memory
// assumes command pins and cke arrive from pins; apb slave on pclk
// Functional notes
// - refresh busy from registering edge, fixed time
// - self refresh: refresh with cke falling
// - cke low with nop enters power-down
// - power-down gates buffers; precharge freezes dll
// - no refresh during power-down
// - cke high with nop exits power-down
module drps_core
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        cke_pin,
   input  wire logic [3:0]  cmd_pin,
   input  wire logic        a10_pin,
   input  wire logic        odt_pin,
   output logic             buffers_on,
   output logic             dll_frozen,
   output logic             refresh_busy,
   output logic             read_allowed,
   output logic             nonread_allowed
);
   typedef struct packed
   {
      logic [1:0]           cke_s;
      logic [1:0]           cke_s2;
      logic [3:0]           cmd_s;
      logic [3:0]           cmd_s2;
      logic                 odt_s;
      logic                 odt_s2;
      logic                 a10_s;
      logic                 a10_s2;
      logic                 cke_prev;
      drps_pkg::drps_state_type state;
      logic                 slow_exit;
      logic                 dll_unlocked;
      logic                 need_dll_reset;
      logic [1:0]           cke_run;
      logic                 rd_ok;
      logic                 nrd_ok;
      logic                 viol;
      logic [31:0]          rdata;
   } drps_core_type;

   drps_core_type st_r;
   drps_core_type st_nxt;
   drps_cnt_if    ref_c ();
   drps_cnt_if    exit_c ();
   drps_cnt_if    rd_c ();

   drps_timer u_ref  (.pclk(pclk), .presetn(presetn), .cnt(ref_c));
   drps_timer u_exit (.pclk(pclk), .presetn(presetn), .cnt(exit_c));
   drps_timer u_rd   (.pclk(pclk), .presetn(presetn), .cnt(rd_c));

   logic       cke;
   logic [3:0] cmd;
   logic       is_nop;
   logic       apb_wr;
   logic       apb_rd;

   always_comb
   begin
      cke    = st_r.cke_s2[0];
      cmd    = st_r.cmd_s2;
      is_nop = (cmd == drps_pkg::CMD_NOP) || cmd[3];
      apb_wr = psel && penable && pwrite;
      apb_rd = psel && !penable && !pwrite;
      st_nxt = st_r;
      ref_c.load   = 1'b0;
      ref_c.value  = 8'h00;
      exit_c.load  = 1'b0;
      exit_c.value = 8'h00;
      rd_c.load    = 1'b0;
      rd_c.value   = 8'h00;
      // two flops on every pin before use
      st_nxt.cke_s  = {1'b0, cke_pin};
      st_nxt.cke_s2 = st_r.cke_s;
      st_nxt.cmd_s  = cmd_pin;
      st_nxt.cmd_s2 = st_r.cmd_s;
      st_nxt.a10_s  = a10_pin;
      st_nxt.a10_s2 = st_r.a10_s;
      st_nxt.odt_s  = odt_pin;
      st_nxt.odt_s2 = st_r.odt_s;
      st_nxt.cke_prev = cke;
      // write-one clear first, so any set further down wins
      if (apb_wr && paddr == drps_pkg::REG_VIOL && pwdata[0])
      begin
         st_nxt.viol = 1'b0;
      end
      // hold counter for the cke level
      if (cke != st_r.cke_prev)
      begin
         st_nxt.cke_run = 2'h1;
      end
      else if (st_r.cke_run != 2'h3)
      begin
         st_nxt.cke_run = st_r.cke_run + 2'h1;
      end
      if (cke != st_r.cke_prev && st_r.cke_run < 2'(drps_pkg::CKE_HOLD_CYC))
      begin
         st_nxt.viol = 1'b1;
      end
      case (st_r.state)
         drps_pkg::ST_IDLE, drps_pkg::ST_ACTIVE:
         begin
            if (st_r.cke_prev && !cke)
            begin
               if (cmd == drps_pkg::CMD_REFRESH && st_r.state == drps_pkg::ST_IDLE)
               begin
                  st_nxt.state  = drps_pkg::ST_SREF;
                  st_nxt.nrd_ok = 1'b0;
                  st_nxt.rd_ok  = 1'b0;
                  if (st_r.odt_s2)
                  begin
                     st_nxt.viol = 1'b1;
                  end
               end
               else if (is_nop)
               begin
                  // bank state picks the power-down flavour
                  st_nxt.state = (st_r.state == drps_pkg::ST_IDLE) ?
                                 drps_pkg::ST_PPD : drps_pkg::ST_APD;
                  st_nxt.need_dll_reset = st_r.dll_unlocked;
               end
               else
               begin
                  st_nxt.viol = 1'b1;
               end
            end
            else if (cke)
            begin
               if (cmd == drps_pkg::CMD_REFRESH)
               begin
                  // refresh busy from the registering edge
                  ref_c.load  = 1'b1;
                  ref_c.value = 8'(drps_pkg::REFRESH_CYC);
               end
               else if (cmd == drps_pkg::CMD_ACTIVATE)
               begin
                  st_nxt.state = drps_pkg::ST_ACTIVE;
               end
               else if (cmd == drps_pkg::CMD_PRECHG && st_r.a10_s2)
               begin
                  st_nxt.state = drps_pkg::ST_IDLE;
               end
               if (cmd == drps_pkg::CMD_READ && !st_r.rd_ok)
               begin
                  st_nxt.viol = 1'b1;
               end
               if (!is_nop && !st_r.nrd_ok)
               begin
                  st_nxt.viol = 1'b1;
               end
            end
         end
         drps_pkg::ST_PPD, drps_pkg::ST_APD:
         begin
            // no refresh runs here: software must wake in time
            if (cke && is_nop)
            begin
               st_nxt.state  = (st_r.state == drps_pkg::ST_PPD) ?
                               drps_pkg::ST_IDLE : drps_pkg::ST_ACTIVE;
               st_nxt.nrd_ok = 1'b0;
               st_nxt.rd_ok  = 1'b0;
               exit_c.load   = 1'b1;
               exit_c.value  = 8'(drps_pkg::PD_EXIT_CYC);
               rd_c.load     = 1'b1;
               rd_c.value    = (st_r.state == drps_pkg::ST_APD && st_r.slow_exit) ?
                               8'(drps_pkg::APD_SLOW_CYC) : 8'(drps_pkg::APD_FAST_CYC);
            end
         end
         drps_pkg::ST_SREF:
         begin
            if (cke && is_nop)
            begin
               st_nxt.state  = drps_pkg::ST_IDLE;
               st_nxt.nrd_ok = 1'b0;
               st_nxt.rd_ok  = 1'b0;
               exit_c.load   = 1'b1;
               exit_c.value  = 8'(drps_pkg::SR_NONREAD_CYC);
               rd_c.load     = 1'b1;
               rd_c.value    = 8'(drps_pkg::SR_READ_CYC);
            end
         end
         default:
         begin
            st_nxt.state = drps_pkg::ST_IDLE;
         end
      endcase
      if (!exit_c.load && exit_c.done)
      begin
         st_nxt.nrd_ok = 1'b1;
      end
      if (!rd_c.load && rd_c.done && exit_c.done)
      begin
         st_nxt.rd_ok = 1'b1;
      end
      // early cke drop after self refresh only once nonread delay met
      if (!st_r.rd_ok && st_r.state == drps_pkg::ST_IDLE && st_r.cke_prev && !cke
          && !st_r.nrd_ok)
      begin
         st_nxt.viol = 1'b1;
      end
      // termination must stay low until read delay met after exit
      if (!st_r.rd_ok && st_r.odt_s2 && cke)
      begin
         st_nxt.viol = 1'b1;
      end
      // apb write to the control word
      if (apb_wr && paddr == drps_pkg::REG_CTRL)
      begin
         st_nxt.slow_exit    = pwdata[drps_pkg::MODE_SLOW_BIT];
         st_nxt.dll_unlocked = pwdata[0];
         if (pwdata[1])
         begin
            st_nxt.need_dll_reset = 1'b0;
         end
      end
      if (apb_rd && paddr == drps_pkg::REG_CTRL)
      begin
         st_nxt.rdata = {19'h0, st_r.slow_exit, 11'h0, st_r.dll_unlocked};
      end
      else if (apb_rd && paddr == drps_pkg::REG_STATUS)
      begin
         st_nxt.rdata = {24'h0, st_r.need_dll_reset, st_r.rd_ok, st_r.nrd_ok,
                         !ref_c.done, 1'b0, st_r.state};
      end
      else if (apb_rd && paddr == drps_pkg::REG_VIOL)
      begin
         st_nxt.rdata = {31'h0, st_r.viol};
      end
      else if (apb_rd)
      begin
         st_nxt.rdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r         <= '0;
         st_r.rd_ok   <= 1'b1;
         st_r.nrd_ok  <= 1'b1;
         // saturated, so the synchroniser filling up is no false short level
         st_r.cke_run <= 2'h3;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // buffers off in any down state; dll frozen only in precharge power-down
   assign buffers_on      = (st_r.state != drps_pkg::ST_PPD) &&
                            (st_r.state != drps_pkg::ST_APD) &&
                            (st_r.state != drps_pkg::ST_SREF);
   assign dll_frozen      = (st_r.state == drps_pkg::ST_PPD);
   assign refresh_busy    = !ref_c.done;
   assign read_allowed    = st_r.rd_ok;
   assign nonread_allowed = st_r.nrd_ok;
   assign prdata          = st_r.rdata;
   assign pready          = 1'b1;
   assign pslverr         = 1'b0;
endmodule : drps_core

// ===== design/drps_timer.sv
// loadable down counter, done while it reads zero
// assumes synchronous load from logic on pclk
module drps_timer
(
   input  wire logic  pclk,
   input  wire logic  presetn,
   drps_cnt_if.timer  cnt
);
   typedef struct packed
   {
      logic [7:0] count;
   } drps_tmr_type;

   drps_tmr_type st_r;
   drps_tmr_type st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      if (cnt.load)
      begin
         st_nxt.count = cnt.value;
      end
      else if (st_r.count != 8'h00)
      begin
         st_nxt.count = st_r.count - 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign cnt.done  = (st_r.count == 8'h00);
   assign cnt.count = st_r.count;
endmodule : drps_timer

// ===== dv/drps_core_bench.sv
// self-checking bench for the refresh and power-down state block
// assumes the controller model drives the memory pins
module drps_core_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] STA = drps_pkg::REG_STATUS;
   localparam logic [7:0] CTL = drps_pkg::REG_CTRL;
   localparam logic [7:0] VIO = drps_pkg::REG_VIOL;
   localparam logic [3:0] NOP = drps_pkg::CMD_NOP;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic [3:0]  cmd_pin;
   logic        pready, pslverr, cke_pin, a10_pin, odt_pin, buffers_on;
   logic        dll_frozen, refresh_busy, read_allowed, nonread_allowed;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   int          fail_count = 0;
   int          checks = 0;
   int          cyc = 0;

   drps_core drps_core_inst
   (
      .pclk            (pclk),
      .presetn         (presetn),
      .psel            (psel),
      .penable         (penable),
      .pwrite          (pwrite),
      .paddr           (paddr),
      .pwdata          (pwdata),
      .prdata          (prdata),
      .pready          (pready),
      .pslverr         (pslverr),
      .cke_pin         (cke_pin),
      .cmd_pin         (cmd_pin),
      .a10_pin         (a10_pin),
      .odt_pin         (odt_pin),
      .buffers_on      (buffers_on),
      .dll_frozen      (dll_frozen),
      .refresh_busy    (refresh_busy),
      .read_allowed    (read_allowed),
      .nonread_allowed (nonread_allowed)
   );
   drps_ctrl_model drps_ctrl_model_inst
   (
      .pclk            (pclk),
      .cke_pin         (cke_pin),
      .cmd_pin         (cmd_pin),
      .a10_pin         (a10_pin),
      .odt_pin         (odt_pin)
   );

   // clock never stops or changes rate, around self refresh too
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task wrap_up;
      if (fail_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   task chk(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
      checks++;
      if ((got & m) !== (e & m))
      begin
         fail_count++;
         $display("unexpected %0t got %h want %h", $time, got, e);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      apb(1'b0, a, 32'h0);
   endtask : rd

   // read results are judged where the access completes
   always @(posedge pclk)
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
         chk(prdata, exp_q.pop_front(), msk_q.pop_front());
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fail_count++;
         wrap_up();
      end
   end

   initial
   begin
      presetn <= 1'b0;
      psel    <= 1'b0;
      penable <= 1'b0;
      pwrite  <= 1'b0;
      paddr   <= 8'h00;
      pwdata  <= 32'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(STA, 32'h60, 32'hF7);
      rd(CTL, 32'h0, 32'hFFFFFFFF);
      apb(1'b1, 8'h0C, 32'hFFFFFFFF);
      rd(8'h0C, 32'h0, 32'hFFFFFFFF);
      drps_ctrl_model_inst.send(drps_pkg::CMD_PRECHG, 1'b1);
      drps_ctrl_model_inst.send(drps_pkg::CMD_REFRESH, 1'b0);
      drps_ctrl_model_inst.idle(1);
      rd(STA, 32'h10, 32'h10);
      drps_ctrl_model_inst.idle(8);
      rd(STA, 32'h0, 32'h17);
      // dll reported unlocked, so power-down entry must flag a reset
      apb(1'b1, CTL, 32'h1);
      drps_ctrl_model_inst.cke_to(1'b0, NOP, 3);
      drps_ctrl_model_inst.idle(3);
      rd(STA, 32'h2, 32'h7);
      chk({30'h0, buffers_on, dll_frozen}, 32'h1, 32'h3);
      drps_ctrl_model_inst.cke_to(1'b1, NOP, 3);
      drps_ctrl_model_inst.idle(6);
      rd(STA, 32'hE0, 32'hE7);
      apb(1'b1, CTL, 32'h2);
      rd(STA, 32'h0, 32'h80);
      apb(1'b1, CTL, 32'h1000);
      drps_ctrl_model_inst.send(drps_pkg::CMD_ACTIVATE, 1'b0);
      drps_ctrl_model_inst.idle(3);
      drps_ctrl_model_inst.cke_to(1'b0, NOP, 3);
      drps_ctrl_model_inst.idle(3);
      rd(STA, 32'h3, 32'h7);
      chk({30'h0, buffers_on, dll_frozen}, 32'h0, 32'h3);
      drps_ctrl_model_inst.cke_to(1'b1, NOP, 3);
      drps_ctrl_model_inst.idle(12);
      rd(STA, 32'h61, 32'h67);
      // a read once allowed must not count as a violation
      drps_ctrl_model_inst.send(drps_pkg::CMD_READ, 1'b0);
      drps_ctrl_model_inst.idle(3);
      drps_ctrl_model_inst.send(drps_pkg::CMD_PRECHG, 1'b1);
      drps_ctrl_model_inst.idle(3);
      drps_ctrl_model_inst.cke_to(1'b0, drps_pkg::CMD_REFRESH, 3);
      drps_ctrl_model_inst.idle(3);
      rd(STA, 32'h4, 32'h7);
      drps_ctrl_model_inst.cke_to(1'b1, NOP, 3);
      drps_ctrl_model_inst.idle(20);
      rd(STA, 32'h20, 32'h60);
      drps_ctrl_model_inst.idle(200);
      rd(STA, 32'h60, 32'h60);
      rd(VIO, 32'h0, 32'h1);
      // clock enable low for two edges only
      drps_ctrl_model_inst.cke_to(1'b0, NOP, 1);
      drps_ctrl_model_inst.cke_to(1'b1, NOP, 3);
      drps_ctrl_model_inst.idle(6);
      rd(VIO, 32'h1, 32'h1);
      apb(1'b1, VIO, 32'h1);
      rd(VIO, 32'h0, 32'h1);
      // termination left on at self refresh entry
      drps_ctrl_model_inst.odt_to(1'b1);
      drps_ctrl_model_inst.cke_to(1'b0, drps_pkg::CMD_REFRESH, 3);
      drps_ctrl_model_inst.odt_to(1'b0);
      drps_ctrl_model_inst.cke_to(1'b1, NOP, 3);
      rd(VIO, 32'h1, 32'h1);
      repeat (3) @(posedge pclk);
      wrap_up();
   end
endmodule : drps_core_bench

// ===== dv/drps_core_checker.sv
// concurrent checks on the pins and apb side of the state block
// assumes one pclk domain with presetn active low
module drps_core_checker
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        cke_pin,
   input wire logic [3:0]  cmd_pin,
   input wire logic        buffers_on,
   input wire logic        dll_frozen,
   input wire logic        refresh_busy,
   input wire logic        read_allowed,
   input wire logic        nonread_allowed
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // run length of busy, so a stuck busy shows up
   logic [3:0]             busy_cnt_r;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         busy_cnt_r <= 4'h0;
      else
         busy_cnt_r <= refresh_busy ? busy_cnt_r + 4'h1 : 4'h0;

   a_apb_zero_wait: assert property (psel && penable |-> pready && !pslverr)
      else $error("apb access waited or erred");
   a_refresh_busy_start: assert property
      (cke_pin && $past(cke_pin) && cmd_pin == drps_pkg::CMD_REFRESH |-> ##[1:4] refresh_busy)
      else $error("refresh did not raise busy");
   a_refresh_busy_len: assert property (busy_cnt_r <= drps_pkg::REFRESH_CYC)
      else $error("refresh busy too long");
   a_pd_entry_seen: assert property
      (($fell(cke_pin) && (cmd_pin[3] || cmd_pin == drps_pkg::CMD_NOP)) ##1 !cke_pin
       ##1 !cke_pin |-> ##[0:3] !buffers_on)
      else $error("power-down not entered");
   a_sref_entry_seen: assert property
      (($fell(cke_pin) && cmd_pin == drps_pkg::CMD_REFRESH) ##1 !cke_pin
       |-> ##[1:4] (!buffers_on && !dll_frozen))
      else $error("self refresh not entered");
   a_pd_exit_seen: assert property
      (($rose(cke_pin) && (cmd_pin[3] || cmd_pin == drps_pkg::CMD_NOP)) ##1 cke_pin
       |-> ##[1:4] buffers_on)
      else $error("power-down not left");
   a_frozen_only_down: assert property (dll_frozen |-> !buffers_on)
      else $error("dll frozen with buffers on");
   a_read_needs_nonread: assert property (read_allowed |-> nonread_allowed)
      else $error("read allowed before nonread");
   a_read_lags_exit: assert property
      ($rose(nonread_allowed) && !read_allowed |-> ##1 !read_allowed [*4])
      else $error("read allowed too early after exit");
endmodule : drps_core_checker

bind drps_core drps_core_checker drps_core_checker_inst
(
   .pclk            (pclk),
   .presetn         (presetn),
   .psel            (psel),
   .penable         (penable),
   .pready          (pready),
   .pslverr         (pslverr),
   .cke_pin         (cke_pin),
   .cmd_pin         (cmd_pin),
   .buffers_on      (buffers_on),
   .dll_frozen      (dll_frozen),
   .refresh_busy    (refresh_busy),
   .read_allowed    (read_allowed),
   .nonread_allowed (nonread_allowed)
);

// ===== dv/drps_ctrl_model.sv
// behavioural memory controller driving clock enable and commands
// assumes the bench sequences it through its tasks on pclk
module drps_ctrl_model
(
   input  wire logic  pclk,
   output logic       cke_pin,
   output logic [3:0] cmd_pin,
   output logic       a10_pin,
   output logic       odt_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   int                seed = 32'h13619128;
   int                r;
   initial
   begin
      cke_pin = 1'b1;
      cmd_pin = drps_pkg::CMD_NOP;
      a10_pin = 1'b0;
      odt_pin = 1'b0;
   end
   // deselect leaves the other bits undefined, so they wander
   task idle(input int n);
      repeat (n)
      begin
         @(posedge pclk);
         r = $random(seed);
         cmd_pin <= {1'b1, r[2:0]};
         a10_pin <= r[3];
      end
   endtask : idle
   task send(input logic [3:0] c, input logic a10);
      @(posedge pclk);
      cmd_pin <= c;
      a10_pin <= a10;
      idle(1);
   endtask : send
   // caller keeps bursts done before going low; banks may stay open for active power-down
   task cke_to(input logic v, input logic [3:0] c, input int hold);
      @(posedge pclk);
      cke_pin <= v;
      cmd_pin <= c;
      idle(hold);
   endtask : cke_to
   task odt_to(input logic v);
      @(posedge pclk);
      odt_pin <= v;
   endtask : odt_to
endmodule : drps_ctrl_model

// ===== shared/drps_cnt_if.sv
// carrier between the main block and its down counter
// assumes both ends share pclk
interface drps_cnt_if;
   logic             load;
   logic [7:0]       value;
   logic             done;
   logic [7:0]       count;
   modport owner (output load, output value, input done, input count);
   modport timer (input load, input value, output done, output count);
endinterface : drps_cnt_if

// ===== shared/drps_pkg.sv
// constants and types for the refresh / power-down state block
// assumes pclk at 40 MHz samples the memory command pins each edge
package drps_pkg;
   localparam int unsigned CLK_MHZ          = 40;
   // refresh busy period in ns, rounded up to whole cycles
   localparam int unsigned REFRESH_NS       = 128;
   localparam int unsigned REFRESH_CYC      = (REFRESH_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned SR_NONREAD_NS    = 138;
   localparam int unsigned SR_NONREAD_CYC   = (SR_NONREAD_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned SR_READ_CYC      = 200;
   localparam int unsigned PD_EXIT_CYC      = 2;
   localparam int unsigned APD_FAST_CYC     = 2;
   localparam int unsigned APD_SLOW_CYC     = 8;
   localparam int unsigned CKE_HOLD_CYC     = 3;
   localparam int unsigned CNT_W            = 8;
   localparam int unsigned MODE_SLOW_BIT    = 12;

   // command encoding {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_DESEL    = 4'h8;
   localparam logic [3:0] CMD_NOP      = 4'h7;
   localparam logic [3:0] CMD_REFRESH  = 4'h1;
   localparam logic [3:0] CMD_ACTIVATE = 4'h3;
   localparam logic [3:0] CMD_PRECHG   = 4'h2;
   localparam logic [3:0] CMD_READ     = 4'h5;

   // apb register byte offsets
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_STATUS   = 8'h04;
   localparam logic [7:0] REG_VIOL     = 8'h08;

   typedef enum logic [2:0]
   {
      ST_IDLE    = 3'b000,
      ST_ACTIVE  = 3'b001,
      ST_PPD     = 3'b010,
      ST_APD     = 3'b011,
      ST_SREF    = 3'b100
   } drps_state_type;
endpackage : drps_pkg
